// file: shared/pm_wake_pkg.sv
// constants, types and register layout for the power and wake control block
package pm_wake_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PHY_RESET_US = 100;
  localparam int unsigned PHY_RESET_CYC = PHY_RESET_US * CLK_MHZ;
  localparam int unsigned WAKE_PULSE_MS = 50;
  localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_MS * 1000 * CLK_MHZ;
  localparam logic [23:0] WAKE_SETTLE_CYC = 24'h000010;
  localparam int unsigned CNT_W = 24;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] BYTE_TEST_OFS = 8'h64;
  localparam logic [7:0] PM_CTRL_OFS = 8'h84;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'hA0;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'hA4;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'hA8;

  // control register field positions
  localparam int unsigned READY_BIT = 0;
  localparam int unsigned PIN_EN_BIT = 1;
  localparam int unsigned POL_BIT = 2;
  localparam int unsigned PULSE_SEL_BIT = 3;
  localparam int unsigned CAUSE_LSB = 4;
  localparam int unsigned DRIVE_TYPE_BIT = 6;
  localparam int unsigned ENERGY_DETECT_EVENT_ENABLE_BIT = 8;
  localparam int unsigned WF_EN_BIT = 9;
  localparam int unsigned PHY_RESET_TRIGGER_BIT = 10;
  localparam int unsigned MODE_LSB = 12;

  // interrupt status layout
  localparam int unsigned IRQ_WAKE_BIT = 0;
  localparam int unsigned IRQ_PHY_DONE_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  localparam logic [1:0] CAUSE_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  typedef enum logic [1:0] {
    full_power_state,
    wake_detect_state,
    energy_detect_state
  } power_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } wake_pin_t;
endpackage

// file: design/cycle_timer.sv
// loadable down-counter that reports busy and a one-cycle done
`timescale 1ns/1ps
module cycle_timer
  import pm_wake_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic [pm_wake_pkg::CNT_W-1:0] load,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= '0;
    else if (ce)
    begin
      if (abort)
        cnt_q <= '0;
      else if (start)
        cnt_q <= load;
      else if (cnt_q != '0)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = ce && !abort && !start && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// file: design/power_management_wake_control.sv
// power state, phy reset, wake cause and wake pin control with an avalon slave
//
// Behaviour
// - power state field selects operating state
// - byte test write wakes reduced-power device
// - control register readable in power saving
// - writes ignored until first read after wake
// - phy reset held minimum time, self-clears
// - wake frame asserts pin and interrupt
// - energy detect asserts pin and interrupt
// - drive type picks open-drain or push-pull
// - wake cause field encodes event source
// - cause clear needs ready and quiet sources
// - pulse select gives timed or static pin
// - clearing cause or enable releases pin
// - polarity sets push-pull active level
// - pin enable gates only the pin
`timescale 1ns/1ps
module power_management_wake_control
  import pm_wake_pkg::*;
#(
  parameter int unsigned PHY_HOLD_CYC = PHY_RESET_CYC,
  parameter int unsigned PULSE_CYC = WAKE_PULSE_CYC
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire pm_wake_pkg::avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wake_frame_event,
  input wire logic energy_event,
  output logic phy_hold_n,
  output pm_wake_pkg::wake_pin_t wake_event_pin,
  output logic wake_interrupt_flag,
  output logic irq
);
  import pm_wake_pkg::*;

  localparam logic [CNT_W-1:0] PHY_LOAD = CNT_W'(PHY_HOLD_CYC);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC);

  // ***********************************************************
  // bus slave
  // ***********************************************************
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  logic ack_q;
  logic req_any;
  logic take;
  logic take_wr;
  logic take_rd;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] readdata_q;

  assign req_any = avs_req.read || avs_req.write;
  assign avs_waitrequest = req_any && !(ack_q && ce);
  assign take = req_any && ack_q && ce;
  assign take_wr = take && avs_req.write;
  assign take_rd = take && avs_req.read;
  assign wmask = lane_mask(avs_req.byteenable);
  assign wbits = avs_req.writedata & wmask;
  assign avs_readdata = readdata_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_q <= 1'b0;
    else if (ce)
      ack_q <= req_any && !ack_q;
  end

  // ***********************************************************
  // control state
  // ***********************************************************
  power_state_t mode_q;
  logic read_seen_q;
  logic pin_en_q;
  logic pol_q;
  logic pulse_sel_q;
  logic drive_type_q;
  logic energy_detect_event_enable_q;
  logic wf_en_q;
  logic [1:0] cause_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic ready;
  logic settle_busy;
  logic phy_busy;
  logic phy_done;
  logic pulse_busy;
  logic wake_req;
  logic wr_ctrl;
  logic wr_ok;

  assign ready = (mode_q == full_power_state) && !settle_busy;
  assign wake_req = take_wr && (avs_req.address == BYTE_TEST_OFS)
                    && (mode_q != full_power_state);
  // only a prior read and full readiness let a write through
  assign wr_ok = take_wr && read_seen_q && ready;
  assign wr_ctrl = wr_ok && (avs_req.address == PM_CTRL_OFS);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      read_seen_q <= 1'b0;
    else if (ce)
    begin
      if (wake_req)
        read_seen_q <= 1'b0;
      else if (take_rd)
        read_seen_q <= 1'b1;
    end
  end

  // reserved code is dropped so the state can never go illegal
  function automatic power_state_t decode_mode(input logic [1:0] code, input power_state_t cur);
    unique case (code)
      2'h0: decode_mode = full_power_state;
      2'h1: decode_mode = wake_detect_state;
      2'h2: decode_mode = energy_detect_state;
      default: decode_mode = cur;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= full_power_state;
    else if (ce)
    begin
      if (wake_req)
        mode_q <= full_power_state;
      else if (wr_ctrl && avs_req.byteenable[1])
        mode_q <= decode_mode(avs_req.writedata[MODE_LSB +: 2], mode_q);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_en_q <= 1'b0;
      pol_q <= 1'b0;
      pulse_sel_q <= 1'b0;
      drive_type_q <= 1'b0;
    end
    else if (ce && wr_ctrl && avs_req.byteenable[0])
    begin
      pin_en_q <= avs_req.writedata[PIN_EN_BIT];
      pol_q <= avs_req.writedata[POL_BIT];
      pulse_sel_q <= avs_req.writedata[PULSE_SEL_BIT];
      drive_type_q <= avs_req.writedata[DRIVE_TYPE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      energy_detect_event_enable_q <= 1'b0;
      wf_en_q <= 1'b0;
    end
    else if (ce && wr_ctrl && avs_req.byteenable[1])
    begin
      energy_detect_event_enable_q <= avs_req.writedata[ENERGY_DETECT_EVENT_ENABLE_BIT];
      wf_en_q <= avs_req.writedata[WF_EN_BIT];
    end
  end

  // ***********************************************************
  // timers: wake settle, phy reset hold, wake pulse
  // ***********************************************************
  cycle_timer u_settle (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(wake_req),
    .abort(1'b0),
    .load(WAKE_SETTLE_CYC),
    .busy(settle_busy),
    .done()
  );

  logic phy_start;
  // a set trigger bit shields the hold from further writes
  assign phy_start = wr_ctrl && wbits[PHY_RESET_TRIGGER_BIT] && !phy_busy;

  cycle_timer u_phy (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(phy_start),
    .abort(1'b0),
    .load(PHY_LOAD),
    .busy(phy_busy),
    .done(phy_done)
  );

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      phy_hold_n <= 1'b1;
    else if (ce)
      phy_hold_n <= !(phy_busy || phy_start);
  end

  // ***********************************************************
  // wake events and cause
  // ***********************************************************
  logic wf_hit;
  logic ed_hit;
  logic new_evt;
  logic static_act;
  logic src_quiet;
  logic [1:0] cause_clr;

  assign wf_hit = wake_frame_event && wf_en_q && (mode_q == wake_detect_state);
  assign ed_hit = energy_event && energy_detect_event_enable_q && (mode_q == energy_detect_state);
  assign new_evt = (wf_hit && !cause_q[1]) || (ed_hit && !cause_q[0]);
  assign src_quiet = !wake_frame_event && !energy_event;
  assign cause_clr = (wr_ctrl && src_quiet) ? wbits[CAUSE_LSB +: 2] : 2'h0;

  // set beats clear so a fresh event is never lost
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cause_q <= CAUSE_RST;
    else if (ce)
      cause_q <= (cause_q & ~cause_clr) | {wf_hit, ed_hit};
  end

  assign static_act = (cause_q[1] && wf_en_q) || (cause_q[0] && energy_detect_event_enable_q);

  cycle_timer u_pulse (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(new_evt && pulse_sel_q),
    .abort(!static_act && !new_evt),
    .load(PULSE_LOAD),
    .busy(pulse_busy),
    .done()
  );

  // ***********************************************************
  // wake pin
  // ***********************************************************
  logic pin_act;
  wake_pin_t pin_d;
  wake_pin_t pin_q;

  assign pin_act = pin_en_q && (pulse_sel_q ? (pulse_busy && static_act) : static_act);

  always_comb
  begin
    if (!drive_type_q)
    begin
      pin_d.level = 1'b0;
      pin_d.oe_n = !pin_act;
    end
    else
    begin
      pin_d.level = pol_q ? pin_act : !pin_act;
      pin_d.oe_n = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_q.level <= 1'b0;
      pin_q.oe_n <= 1'b1;
    end
    else if (ce)
      pin_q <= pin_d;
  end

  assign wake_event_pin = pin_q;

  // ***********************************************************
  // interrupts
  // ***********************************************************
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {phy_done, wf_hit || ed_hit};
  assign irq_clr = (wr_ok && avs_req.address == IRQ_CLEAR_OFS) ? wbits[IRQ_W-1:0] : IRQ_RST;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_status_q <= IRQ_RST;
    else if (ce)
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_enable_q <= IRQ_RST;
    else if (ce && wr_ok && avs_req.address == IRQ_ENABLE_OFS && avs_req.byteenable[0])
      irq_enable_q <= avs_req.writedata[IRQ_W-1:0];
  end

  assign wake_interrupt_flag = irq_status_q[IRQ_WAKE_BIT];
  assign irq = |(irq_status_q & irq_enable_q);

  // ***********************************************************
  // read data
  // ***********************************************************
  logic [31:0] ctrl_word;

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[MODE_LSB +: 2] = mode_q;
    ctrl_word[PHY_RESET_TRIGGER_BIT] = phy_busy;
    ctrl_word[WF_EN_BIT] = wf_en_q;
    ctrl_word[ENERGY_DETECT_EVENT_ENABLE_BIT] = energy_detect_event_enable_q;
    ctrl_word[DRIVE_TYPE_BIT] = drive_type_q;
    ctrl_word[CAUSE_LSB +: 2] = cause_q;
    ctrl_word[PULSE_SEL_BIT] = pulse_sel_q;
    ctrl_word[POL_BIT] = pol_q;
    ctrl_word[PIN_EN_BIT] = pin_en_q;
    ctrl_word[READY_BIT] = ready;
  end

  // control stays readable whatever the power state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      readdata_q <= 32'h0000_0000;
    else if (ce && avs_req.read && !ack_q)
    begin
      unique case (avs_req.address)
        PM_CTRL_OFS: readdata_q <= ctrl_word;
        IRQ_STATUS_OFS: readdata_q <= {30'h0, irq_status_q};
        IRQ_ENABLE_OFS: readdata_q <= {30'h0, irq_enable_q};
        default: readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [CNT_W-1:0] phy_len_q;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      phy_len_q <= '0;
    else if (ce)
      phy_len_q <= phy_busy ? phy_len_q + 1'b1 : '0;
  end

  a_mode_select: assert property ((wr_ctrl && avs_req.byteenable[1]
    && avs_req.writedata[MODE_LSB +: 2] == 2'h2) |=> mode_q == energy_detect_state)
    else $error("mode write not applied");
  a_test_wakes: assert property (wake_req |=> (mode_q == full_power_state) && !ready)
    else $error("byte test write did not wake");
  a_ctrl_read: assert property ((ce && avs_req.read && !ack_q && avs_req.address == PM_CTRL_OFS)
    |=> readdata_q[MODE_LSB +: 2] == $past(mode_q))
    else $error("control read wrong in power save");
  a_write_blocked: assert property ((take_wr && !read_seen_q && avs_req.address == PM_CTRL_OFS)
    |=> $stable(pin_en_q) && $stable(wf_en_q))
    else $error("write took effect before a read");
  a_phy_hold: assert property ((ce && phy_done) |-> phy_len_q == PHY_LOAD - 1'b1)
    else $error("phy reset hold length wrong");
  a_wake_irq: assert property ((ce && (wf_hit || ed_hit)) |=> irq_status_q[IRQ_WAKE_BIT])
    else $error("wake interrupt not raised");
  a_od_low: assert property ((ce && !drive_type_q) |=> !wake_event_pin.level)
    else $error("open drain drove high");
  a_cause_both: assert property ((ce && ((wf_hit && cause_q[0]) || (ed_hit && cause_q[1])))
    |=> cause_q == 2'h3)
    else $error("multiple cause not reported");
  a_clear_gate: assert property ((ce && !ready && cause_q[0]) |=> cause_q[0])
    else $error("cause cleared while not ready");
  a_pulse_run: assert property ((ce && new_evt && pulse_sel_q) |=> pulse_busy[*2])
    else $error("wake pulse not started");
  a_enable_off: assert property ((ce && !pin_en_q && drive_type_q)
    |=> wake_event_pin.level == !$past(pol_q))
    else $error("disabled pin shows active");
  a_pol_high: assert property ((ce && drive_type_q && pol_q && pin_act) |=> wake_event_pin.level)
    else $error("push pull polarity wrong");
  a_ready_low: assert property ((ce && wake_req) |=> !ready[*8])
    else $error("ready set in reduced power");
endmodule

// file: verif/tb.sv
// self-checking bench for the power state and wake control block
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
  import pm_wake_pkg::*;
  // short counts keep the run brief
  localparam int unsigned HOLD = 20;
  localparam int unsigned PULSE = 30;
  int n_errors = 0;
  int total_checks = 0;
  logic core_clk;
  logic arst_n;
  logic ce;
  avmm_req_t req;
  logic [31:0] rdata;
  logic wreq;
  logic wf_ev;
  logic en_ev;
  logic phy_hold_n;
  wake_pin_t pin;
  logic flag;
  logic irq;

  power_management_wake_control #(.PHY_HOLD_CYC(HOLD), .PULSE_CYC(PULSE)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .wake_frame_event(wf_ev), .energy_event(en_ev),
    .phy_hold_n(phy_hold_n), .wake_event_pin(pin), .wake_interrupt_flag(flag), .irq(irq));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ********************
  // bus and helper tasks
  // ********************
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    begin
      n = 0;
      @(posedge core_clk);
      req.address <= a;
      req.write <= wr;
      req.read <= !wr;
      req.writedata <= wd;
      req.byteenable <= 4'hF;
      do
      begin
        @(posedge core_clk);
        n++;
      end
      while (wreq !== 1'b0 && n < 100);
      `CHK(wreq, 1'b0)
      rd = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    begin
      bus(1'b1, a, d, x);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    begin
      bus(1'b0, a, 32'h0, d);
      `CHK(d, exp)
    end
  endtask

  task automatic pin_chk(input logic lvl, input logic oe_n);
    begin
      // the pin is registered one edge behind the control fields
      @(posedge core_clk);
      @(negedge core_clk);
      `CHK(pin, {lvl, oe_n})
    end
  endtask

  // one-cycle event level, then wait until the pin has had its two edges
  task automatic ev(input logic frame);
    begin
      @(posedge core_clk);
      if (frame)
        wf_ev <= 1'b1;
      else
        en_ev <= 1'b1;
      @(posedge core_clk);
      wf_ev <= 1'b0;
      en_ev <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask

  task automatic wake_up(input logic [31:0] exp);
    begin
      wr(BYTE_TEST_OFS, 32'hA5A5A5A5);
      rd_chk(PM_CTRL_OFS, exp & 32'hFFFFCFFE);
      repeat (int'(WAKE_SETTLE_CYC) + 4) @(negedge core_clk);
      rd_chk(PM_CTRL_OFS, (exp & 32'hFFFFCFFE) | 32'h1);
    end
  endtask

  task automatic stop_test;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // *********
  // scenarios
  // *********
  task automatic s_write_gate;
    begin
      wr(PM_CTRL_OFS, 32'h2);
      rd_chk(PM_CTRL_OFS, 32'h1);
      `CHK({phy_hold_n, pin.oe_n, irq, flag}, 4'hC)
      wr(PM_CTRL_OFS, 32'h2);
      rd_chk(PM_CTRL_OFS, 32'h3);
      wr(PM_CTRL_OFS, 32'h3002);
      rd_chk(PM_CTRL_OFS, 32'h3);
      rd_chk(8'hF0, 32'h0);
      wr(PM_CTRL_OFS, 32'h0);
    end
  endtask

  task automatic s_phy_reset;
    int cnt;
    begin
      wr(PM_CTRL_OFS, 32'h400);
      repeat (2) @(negedge core_clk);
      cnt = 0;
      while (phy_hold_n === 1'b0 && cnt < 500)
      begin
        @(negedge core_clk);
        cnt++;
      end
      `CHK(cnt + 2 >= HOLD, 1'b1)
      rd_chk(PM_CTRL_OFS, 32'h1);
      rd_chk(IRQ_STATUS_OFS, 32'h2);
      `CHK(irq, 1'b0)
      wr(IRQ_ENABLE_OFS, 32'h3);
      @(negedge core_clk);
      `CHK(irq, 1'b1)
      wr(IRQ_CLEAR_OFS, 32'h2);
      rd_chk(IRQ_STATUS_OFS, 32'h0);
      `CHK(irq, 1'b0)
      wr(PM_CTRL_OFS, 32'h400);
      rd_chk(PM_CTRL_OFS, 32'h401);
      wr(PM_CTRL_OFS, 32'h0);
      rd_chk(PM_CTRL_OFS, 32'h401);
      repeat (HOLD + 10) @(negedge core_clk);
      rd_chk(PM_CTRL_OFS, 32'h1);
      wr(IRQ_CLEAR_OFS, 32'h2);
    end
  endtask

  task automatic s_wake_static;
    begin
      wr(PM_CTRL_OFS, 32'h1246);
      rd_chk(PM_CTRL_OFS, 32'h1246);
      pin_chk(1'b0, 1'b0);
      ev(1'b0);
      rd_chk(PM_CTRL_OFS, 32'h1246);
      ev(1'b1);
      `CHK(pin, 2'b10)
      `CHK({flag, irq}, 2'b11)
      rd_chk(PM_CTRL_OFS, 32'h1266);
      wake_up(32'h0266);
      pin_chk(1'b1, 1'b0);
    end
  endtask

  task automatic s_multi_cause;
    begin
      wr(PM_CTRL_OFS, 32'h2146);
      pin_chk(1'b0, 1'b0);
      ev(1'b0);
      `CHK(pin, 2'b10)
      rd_chk(PM_CTRL_OFS, 32'h2176);
      wake_up(32'h0176);
      @(posedge core_clk);
      en_ev <= 1'b1;
      wr(PM_CTRL_OFS, 32'h0176);
      rd_chk(PM_CTRL_OFS, 32'h0177);
      @(posedge core_clk);
      en_ev <= 1'b0;
      wr(PM_CTRL_OFS, 32'h0176);
      rd_chk(PM_CTRL_OFS, 32'h0147);
      pin_chk(1'b0, 1'b0);
      wr(IRQ_CLEAR_OFS, 32'h1);
      rd_chk(IRQ_STATUS_OFS, 32'h0);
      `CHK({flag, irq}, 2'b00)
      wr(PM_CTRL_OFS, 32'h0140);
      pin_chk(1'b1, 1'b0);
    end
  endtask

  task automatic s_energy_pulse;
    int cnt;
    begin
      wr(PM_CTRL_OFS, 32'h210C);
      ev(1'b0);
      `CHK(pin.oe_n, 1'b1)
      `CHK({flag, irq}, 2'b11)
      wake_up(32'h011C);
      wr(PM_CTRL_OFS, 32'h013C);
      rd_chk(PM_CTRL_OFS, 32'h010D);
      wr(IRQ_CLEAR_OFS, 32'h1);
      wr(PM_CTRL_OFS, 32'h210E);
      @(negedge core_clk);
      `CHK(pin.oe_n, 1'b1)
      ev(1'b0);
      `CHK(pin, 2'b00)
      cnt = 0;
      while (pin.oe_n === 1'b0 && cnt < 1000)
      begin
        @(negedge core_clk);
        cnt++;
      end
      `CHK(cnt + 3 >= PULSE && cnt <= PULSE + 3, 1'b1)
      `CHK(pin.oe_n, 1'b1)
      rd_chk(PM_CTRL_OFS, 32'h211E);
      wake_up(32'h011E);
    end
  endtask

  // ****************
  // main and timeout
  // ****************
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    wf_ev = 1'b0;
    en_ev = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    s_write_gate();
    s_phy_reset();
    s_wake_static();
    s_multi_cause();
    s_energy_pulse();
    stop_test();
  end

  // whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
endmodule
